// ===== rtl/ct_unit_cfg.svh
// address map, field positions and reset values of the counter/timer
`ifndef CT_UNIT_CFG_SVH
`define CT_UNIT_CFG_SVH

`define CT_ADDR_AUX       4'h4
`define CT_ADDR_MASK      4'h5
`define CT_ADDR_HIGH      4'h6
`define CT_ADDR_LOW       4'h7
`define CT_ADDR_ROUTE     4'hD
`define CT_ADDR_START     4'hE
`define CT_ADDR_STOP      4'hF

`define CT_READY_BIT      3
`define CT_MODE_TIMER_BIT 6
`define CT_SRC_HI         5
`define CT_SRC_LO         4
`define CT_ROUTE_HI       3
`define CT_ROUTE_LO       2
`define CT_ROUTE_CT_OUT   2'h1

`define CT_COUNT_ONE      16'h0001
`define CT_COUNT_ZERO     16'h0000
`define CT_COUNT_WRAP     16'hFFFF
`define CT_COUNT_RESET    16'h0000
`define CT_BYTE_RESET     8'h00
`define CT_BYTE_ZERO      8'h00
`define CT_NIBBLE_ZERO    4'h0
`define CT_LOW3_ZERO      3'h0
`define CT_PIN_IDLE       1'b1

`endif

// ===== rtl/ct_unit_pkg.sv
// types shared by the counter/timer files
package ct_unit_pkg;

	// one taken bus access, valid for a single cycle
	typedef struct packed {
		logic       rd_start;
		logic       wr_start;
		logic [3:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	typedef enum logic {
		CT_STOPPED,
		CT_RUNNING
	} run_state_t;

endpackage

// ===== rtl/ct_bus_iface.sv
// turns the parallel bus strobes into one-cycle access pulses
`timescale 1ns/1ps

module ct_bus_iface (
	input  wire logic                  sys_clk,
	input  wire logic                  resetn,
	input  wire logic                  cs_n,
	input  wire logic                  rd_n,
	input  wire logic                  wr_n,
	input  wire logic [3:0]            addr,
	input  wire logic [7:0]            wdata,
	output ct_unit_pkg::bus_req_t      req
);

	logic rd_act_reg;
	logic wr_act_reg;
	logic rd_act;
	logic wr_act;

	// a held strobe must act once only: command reads have side effects
	assign rd_act = !cs_n && !rd_n;
	assign wr_act = !cs_n && !wr_n;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rd_act_reg <= 1'b0;
			wr_act_reg <= 1'b0;
		end else begin
			rd_act_reg <= rd_act;
			wr_act_reg <= wr_act;
		end
	end

	assign req.rd_start = rd_act && !rd_act_reg;
	assign req.wr_start = wr_act && !wr_act_reg;
	assign req.addr     = addr;
	assign req.wdata    = wdata;

endmodule

// ===== rtl/ct_src_select.sv
// synchronises the clock sources and gives a pulse per rising edge
`timescale 1ns/1ps

module ct_src_select #(
	parameter int NSRC = 4
) (
	input  wire logic                    sys_clk,
	input  wire logic                    resetn,
	input  wire logic [NSRC-1:0]         src,
	input  wire logic [$clog2(NSRC)-1:0] sel,
	output logic                         tick
);

	logic [NSRC-1:0] meta_reg;
	logic [NSRC-1:0] sync_reg;
	logic            last_reg;
	logic            picked;

	// every source is synchronised so a select change sees no metastable bit
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			meta_reg <= '0;
			sync_reg <= '0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= src;
			sync_reg <= meta_reg;
			last_reg <= picked;
		end
	end

	assign picked = sync_reg[sel];
	assign tick   = picked && !last_reg;

endmodule

// ===== rtl/uart_counter_timer_unit.sv
// 16-bit counter/timer of the dual serial controller
// Operation
// - one 16-bit down counter, counter or timer
// - reload is high:low preload bytes, writable anytime
// - reset leaves the unit in counter mode
// - counter start read loads reload and runs
// - step 0x0001 to 0x0000 sets ready flag
// - interrupt asserted only when mask bit unmasked
// - counter wraps to 0xFFFF and keeps counting
// - counter ignores new reload until next start or received-character reload
// - counter stop read halts and clears flag
// - received character reloads and restarts time-out
// - time-out expiry raises counter-ready, not receiver-ready
// - timer cannot stop; stop only clears flag
// - timer square wave period twice reload ticks
// - timer start drives output high and reloads
// - timer toggles output and reloads at terminal
// - timer flag set on each output rising edge at terminal count, not on the start read
// - timer adopts reload at terminal or start
// - aux control picks source, routing drives pin
`timescale 1ns/1ps
`include "ct_unit_cfg.svh"

module uart_counter_timer_unit #(
	parameter int NSRC = 4
) (
	input  wire logic            sys_clk,
	input  wire logic            resetn,
	input  wire logic            cs_n,
	input  wire logic            rd_n,
	input  wire logic            wr_n,
	input  wire logic [3:0]      addr,
	input  wire logic [7:0]      wdata,
	input  wire logic [NSRC-1:0] ct_src,
	input  wire logic            rx_char_loaded_a,
	input  wire logic            rx_char_loaded_b,
	input  wire logic            timeout_enable,
	input  wire logic            timeout_channel_b,
	output logic [7:0]           rdata,
	output logic                 rdata_oe,
	output logic                 irq_n,
	output logic                 general_output_pin,
	output logic                 timer_baud_clk
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	ct_unit_pkg::bus_req_t   req;
	ct_unit_pkg::run_state_t state_reg;
	ct_unit_pkg::run_state_t state_next;
	logic [15:0]             count_reg;
	logic [15:0]             count_next;
	logic [7:0]              reload_high_reg;
	logic [7:0]              reload_low_reg;
	logic [7:0]              mask_reg;
	logic [7:0]              aux_reg;
	logic [7:0]              route_reg;
	logic                    flag_reg;
	logic                    flag_next;
	logic                    out_reg;
	logic                    out_next;
	logic                    tc_set;
	logic [7:0]              rdata_reg;
	logic                    rdata_oe_reg;
	logic                    irq_n_reg;
	logic                    pin_reg;
	logic                    tick;
	logic [15:0]             reload;
	logic                    timer_mode;
	logic                    start_cmd;
	logic                    stop_cmd;
	logic                    rx_event;
	logic [7:0]              rd_value;
	logic [7:0]              flags_byte;

	// true for the addresses this unit answers on a read
	function automatic logic is_read_addr(input logic [3:0] a);
		is_read_addr = (a == `CT_ADDR_MASK) || (a == `CT_ADDR_HIGH) ||
			(a == `CT_ADDR_LOW) || (a == `CT_ADDR_START) ||
			(a == `CT_ADDR_STOP);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// submodules

	ct_bus_iface u_bus (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.cs_n    (cs_n),
		.rd_n    (rd_n),
		.wr_n    (wr_n),
		.addr    (addr),
		.wdata   (wdata),
		.req     (req)
	);

	ct_src_select #(.NSRC(NSRC)) u_src (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.src     (ct_src),
		.sel     (aux_reg[`CT_SRC_HI:`CT_SRC_LO]),
		.tick    (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// command decode

	assign reload     = {reload_high_reg, reload_low_reg};
	assign timer_mode = aux_reg[`CT_MODE_TIMER_BIT];
	assign start_cmd  = req.rd_start && (req.addr == `CT_ADDR_START);
	assign stop_cmd   = req.rd_start && (req.addr == `CT_ADDR_STOP);
	// only one channel at a time can own the time-out
	assign rx_event   = timeout_enable && !timer_mode &&
		(timeout_channel_b ? rx_char_loaded_b : rx_char_loaded_a);

	////////////////////////////////////////////////////////////////////////
	// count engine: start wins over a character, which wins over a tick

	always_comb begin
		count_next = count_reg;
		state_next = state_reg;
		out_next   = out_reg;
		tc_set     = 1'b0;
		if (start_cmd) begin
			count_next = reload;
			state_next = ct_unit_pkg::CT_RUNNING;
			out_next   = timer_mode;
		end else if (rx_event) begin
			count_next = reload;
			state_next = ct_unit_pkg::CT_RUNNING;
		end else if (stop_cmd && !timer_mode) begin
			state_next = ct_unit_pkg::CT_STOPPED;
		end else if (tick && state_reg == ct_unit_pkg::CT_RUNNING) begin
			if (timer_mode) begin
				if (count_reg == `CT_COUNT_ONE) begin
					// terminal count folds into the reload: half period = reload
					count_next = reload;
					out_next   = !out_reg;
					tc_set     = !out_reg;
				end else begin
					count_next = count_reg - `CT_COUNT_ONE;
				end
			end else begin
				count_next = count_reg - `CT_COUNT_ONE;
				if (count_reg == `CT_COUNT_ONE) begin
					tc_set   = 1'b1;
					out_next = 1'b1;
				end
			end
		end
	end

	// a terminal count in the clearing cycle is kept
	assign flag_next = tc_set || (flag_reg && !stop_cmd);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			count_reg <= `CT_COUNT_RESET;
			state_reg <= ct_unit_pkg::CT_STOPPED;
			out_reg   <= 1'b0;
			flag_reg  <= 1'b0;
		end else begin
			count_reg <= count_next;
			state_reg <= state_next;
			out_reg   <= out_next;
			flag_reg  <= flag_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// writable registers

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reload_high_reg <= `CT_BYTE_RESET;
			reload_low_reg  <= `CT_BYTE_RESET;
			mask_reg        <= `CT_BYTE_RESET;
			aux_reg         <= `CT_BYTE_RESET;
			route_reg       <= `CT_BYTE_RESET;
		end else if (req.wr_start) begin
			if (req.addr == `CT_ADDR_HIGH) begin
				reload_high_reg <= req.wdata;
			end else if (req.addr == `CT_ADDR_LOW) begin
				reload_low_reg <= req.wdata;
			end else if (req.addr == `CT_ADDR_MASK) begin
				mask_reg <= req.wdata;
			end else if (req.addr == `CT_ADDR_AUX) begin
				aux_reg <= req.wdata;
			end else if (req.addr == `CT_ADDR_ROUTE) begin
				route_reg <= req.wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path; count bytes are not latched together, see borrow hazard

	assign flags_byte = {`CT_NIBBLE_ZERO, flag_reg, `CT_LOW3_ZERO};
	assign rd_value =
		(req.addr == `CT_ADDR_MASK) ? flags_byte :
		(req.addr == `CT_ADDR_HIGH) ? count_reg[15:8] :
		(req.addr == `CT_ADDR_LOW)  ? count_reg[7:0] :
		`CT_BYTE_ZERO;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_reg    <= `CT_BYTE_RESET;
			rdata_oe_reg <= 1'b0;
		end else begin
			if (req.rd_start) begin
				rdata_reg <= rd_value;
			end
			rdata_oe_reg <= !cs_n && !rd_n && is_read_addr(addr);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs: interrupt, pin routing, baud clock

	// pin idles high unless routing selects the counter/timer output
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irq_n_reg <= 1'b1;
			pin_reg   <= `CT_PIN_IDLE;
		end else begin
			irq_n_reg <= !(flag_next && mask_reg[`CT_READY_BIT]);
			pin_reg   <= (route_reg[`CT_ROUTE_HI:`CT_ROUTE_LO] ==
				`CT_ROUTE_CT_OUT) ? out_next : `CT_PIN_IDLE;
		end
	end

	assign rdata              = rdata_reg;
	assign rdata_oe           = rdata_oe_reg;
	assign irq_n              = irq_n_reg;
	assign general_output_pin = pin_reg;
	assign timer_baud_clk     = out_reg;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_run_tick;
		state_reg == ct_unit_pkg::CT_RUNNING && tick && !start_cmd &&
			!rx_event && !stop_cmd && !req.wr_start;
	endsequence

	sequence s_timer_rise;
		timer_mode && !out_reg && count_reg == `CT_COUNT_ONE ##0 s_run_tick;
	endsequence

	property p_counter_tc;
		!timer_mode && count_reg == `CT_COUNT_ONE ##0 s_run_tick
			|=> count_reg == `CT_COUNT_ZERO && flag_reg;
	endproperty
	a_counter_tc: assert property (p_counter_tc)
		else $error("terminal count did not set ready flag");

	property p_wrap;
		!timer_mode && count_reg == `CT_COUNT_ZERO ##0 s_run_tick
			|=> count_reg == `CT_COUNT_WRAP;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("counter did not wrap to all ones");

	property p_start_load;
		start_cmd && !req.wr_start |=> count_reg == $past(reload) &&
			state_reg == ct_unit_pkg::CT_RUNNING;
	endproperty
	a_start_load: assert property (p_start_load)
		else $error("start read did not load and run");

	// a character in the same cycle restarts the time-out instead
	property p_stop;
		stop_cmd && !timer_mode && !rx_event |=>
			state_reg == ct_unit_pkg::CT_STOPPED && !flag_reg && irq_n;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop read did not halt and clear");

	property p_timer_nostop;
		stop_cmd && timer_mode && state_reg == ct_unit_pkg::CT_RUNNING &&
			!req.wr_start |=> state_reg == ct_unit_pkg::CT_RUNNING &&
			flag_reg == (out_reg && !$past(out_reg));
	endproperty
	a_timer_nostop: assert property (p_timer_nostop)
		else $error("timer halted on stop read");

	property p_irq;
		// the request is registered, so it follows a mask write one edge late
		!(flag_reg && $past(mask_reg[`CT_READY_BIT])) |-> irq_n;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt asserted while masked or idle");

	property p_timer_start;
		start_cmd && timer_mode && !req.wr_start |=>
			out_reg && timer_baud_clk ##0 count_reg == $past(reload);
	endproperty
	a_timer_start: assert property (p_timer_start)
		else $error("timer start did not set output high");

	property p_timer_toggle;
		timer_mode && count_reg == `CT_COUNT_ONE ##0 s_run_tick |=>
			out_reg != $past(out_reg) && count_reg == $past(reload);
	endproperty
	a_timer_toggle: assert property (p_timer_toggle)
		else $error("timer did not toggle and reload");

	property p_timer_flag;
		s_timer_rise |=> flag_reg && out_reg;
	endproperty
	a_timer_flag: assert property (p_timer_flag)
		else $error("ready flag missing on rising output");

	property p_timeout;
		rx_event && !start_cmd |=> count_reg == $past(reload) &&
			state_reg == ct_unit_pkg::CT_RUNNING;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("received character did not reload");

	property p_hold;
		state_reg == ct_unit_pkg::CT_STOPPED && !start_cmd && !rx_event
			|=> $stable(count_reg);
	endproperty
	a_hold: assert property (p_hold)
		else $error("count moved while stopped");

endmodule

// ===== tb/host_bus_model.sv
// host cpu model that drives the parallel register bus
`timescale 1ns/1ps

module host_bus_model (
	input  wire logic       sys_clk,
	input  wire logic [7:0] rdata,
	input  wire logic       rdata_oe,
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic [3:0]      addr,
	output logic [7:0]      wdata
);
	logic [7:0] rd_val;
	logic       oe_val;

	// bus idle from time zero
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
	end

	////////////////////////////////////////
	// strobe held two edges, then released for one edge; released lines
	// show the inverse so a stale address never looks valid
	task automatic access(input logic rd, input logic [3:0] a,
		input logic [7:0] d);
		@(negedge sys_clk);
		cs_n = 1'b0;
		rd_n = !rd;
		wr_n = rd;
		addr = a;
		wdata = d;
		repeat (2) @(negedge sys_clk);
		rd_val = rdata;
		oe_val = rdata_oe;
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = ~a;
		wdata = ~d;
		@(negedge sys_clk);
	endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench of the counter/timer unit
`timescale 1ns/1ps

module testbench;
	logic        sys_clk, resetn, rx_a, rx_b, to_en, to_b;
	logic [3:0]  ct_src;
	logic        cs_n, rd_n, wr_n, rdata_oe, irq_n, pin, baud;
	logic [3:0]  addr;
	logic [7:0]  wdata, rdata;
	int          fail_count, n_tests, cyc, seed, sel, r;
	logic [15:0] m_cnt, m_rel;
	logic [7:0]  m_mask;
	logic        m_run, m_flag, m_tm, m_out, m_route;

	uart_counter_timer_unit i_dut (.sys_clk(sys_clk), .resetn(resetn),
		.cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .wdata(wdata),
		.ct_src(ct_src), .rx_char_loaded_a(rx_a), .rx_char_loaded_b(rx_b),
		.timeout_enable(to_en), .timeout_channel_b(to_b), .rdata(rdata),
		.rdata_oe(rdata_oe), .irq_n(irq_n), .general_output_pin(pin),
		.timer_baud_clk(baud));

	host_bus_model h (.sys_clk(sys_clk), .rdata(rdata),
		.rdata_oe(rdata_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.addr(addr), .wdata(wdata));

	////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk1(string n, logic e, logic g);
		chk8(n, {7'h00, e}, {7'h00, g});
	endtask

	// outputs against the model; the pin is 1 unless routed
	task automatic chk_pins();
		chk1("irq_n", !(m_flag && m_mask[3]), irq_n);
		chk1("baud", m_out, baud);
		chk1("pin", m_route ? m_out : 1'b1, pin);
	endtask

	////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		// a source left high would give a false edge on a select change
		if (a == 4'h4)
			ct_src = 4'h0;
		h.access(1'b0, a, d);
		case (a)
			4'h4: begin
				m_tm = d[6];
				sel = d[5:4];
			end
			4'h5: m_mask = d;
			4'h6: m_rel[15:8] = d;
			4'h7: m_rel[7:0] = d;
			4'hD: m_route = (d[3:2] == 2'h1);
			default: ;
		endcase
	endtask

	// expected data is taken before the command acts on the model
	task automatic rd(input logic [3:0] a);
		logic [7:0] e;
		logic       m;
		m = a inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
		e = (a == 4'h5) ? {4'h0, m_flag, 3'h0} :
			(a == 4'h6) ? m_cnt[15:8] : (a == 4'h7) ? m_cnt[7:0] : 8'h00;
		h.access(1'b1, a, 8'h00);
		chk1("rdata_oe", m, h.oe_val);
		if (m)
			chk8("rdata", e, h.rd_val);
		if (a == 4'hE) begin
			m_cnt = m_rel;
			m_run = 1'b1;
			m_out = m_tm;
		end
		if (a == 4'hF) begin
			m_flag = 1'b0;
			m_run = m_run && m_tm;
		end
		chk_pins();
	endtask

	// n edges on the selected source while the others change at random
	task automatic tick(input int n);
		logic [31:0] v;
		repeat (n) begin
			v = $random(seed);
			v[sel] = 1'b1;
			ct_src = v[3:0];
			repeat (4) @(negedge sys_clk);
			v = $random(seed);
			v[sel] = 1'b0;
			ct_src = v[3:0];
			repeat (4) @(negedge sys_clk);
			if (m_run && m_tm && m_cnt == 16'h0001) begin
				m_cnt = m_rel;
				m_out = !m_out;
				m_flag = m_flag | m_out;
			end else if (m_run) begin
				m_flag = m_flag | (m_cnt == 16'h0001);
				m_out = m_out | (m_cnt == 16'h0001);
				m_cnt = m_cnt - 16'h0001;
			end
			chk_pins();
		end
	endtask

	task automatic rx(input logic b);
		rx_a = !b;
		rx_b = b;
		@(negedge sys_clk);
		rx_a = 1'b0;
		rx_b = 1'b0;
		if (to_en && !m_tm && b == to_b) begin
			m_cnt = m_rel;
			m_run = 1'b1;
		end
		repeat (4) @(negedge sys_clk);
		chk_pins();
	endtask

	////////////////////////////////////////
	// clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			stop_test();
		end
	end

	////////////////////////////////////////
	initial begin
		{rx_a, rx_b, to_en, to_b, resetn} = 5'h00;
		{ct_src, m_mask, m_cnt, m_rel} = 44'h0;
		{m_run, m_flag, m_tm, m_out, m_route} = 5'h00;
		{fail_count, n_tests, cyc, sel} = '0;
		seed = 9567;
		repeat (16) @(negedge sys_clk);
		resetn = 1'b1;
		chk_pins();
		rd(4'h6);
		rd(4'h7);
		r = {$random(seed)} % 8 + 2;
		wr(4'h5, 8'h08);
		wr(4'h6, 8'h00);
		wr(4'h7, r[7:0]);
		wr(4'h4, 8'h00);
		rd(4'hE);
		tick(r - 1);
		rd(4'h5);
		tick(1);
		rd(4'h5);
		tick(1);
		rd(4'hF);
		tick(2);
		rd(4'h6);
		rd(4'h7);
		rd(4'hE);
		wr(4'h7, r[7:0] + 8'h03);
		tick(2);
		rd(4'hF);
		rd(4'h7);
		rd(4'hE);
		rd(4'hF);
		rd(4'h7);
		wr(4'h5, 8'h00);
		rd(4'hE);
		tick(r + 3);
		rd(4'h5);
		rd(4'h0);
		rd(4'hB);
		rd(4'hE);
		rd(4'hF);
		wr(4'h5, 8'h08);
		to_en = 1'b1;
		to_b = 1'b1;
		rx(1'b1);
		tick(r + 2);
		rx(1'b0);
		rx(1'b1);
		tick(r + 2);
		rd(4'h5);
		tick(1);
		rd(4'h5);
		rd(4'hF);
		to_en = 1'b0;
		r = {$random(seed)} % 4 + 2;
		wr(4'h7, r[7:0]);
		wr(4'h4, 8'h60);
		rd(4'hE);
		wr(4'hD, 8'h04);
		tick(r);
		tick(r);
		rd(4'h5);
		rd(4'hF);
		tick(1);
		wr(4'h7, r[7:0] + 8'h02);
		tick(r - 1);
		tick(r + 2);
		tick(r + 1);
		rd(4'hE);
		tick(r);
		wr(4'hD, 8'h00);
		tick(r + 2);
		stop_test();
	end
endmodule
